/* rvc_defs.svh */
/*
 * Constants of the radio variant and channel configuration bank:
 * byte addresses of the configuration memory, field positions, reset
 * values, channel-code limits and interval timing.
 * Assumes a byte-wide configuration port and a 100 MHz clock.
 */
`ifndef RVC_DEFS_SVH
`define RVC_DEFS_SVH

// ****************************************************************
// Configuration memory map (byte addresses)
// ****************************************************************
`define RVC_ADDR_W 10
`define RVC_CUST_LAST 10'h0ff
`define RVC_ADDR_VARIANT 10'h100
`define RVC_ADDR_FSEL_A 10'h101
`define RVC_ADDR_FSEL_B 10'h102
`define RVC_ADDR_FSEL_C 10'h103
`define RVC_ADDR_SRC0 10'h110
`define RVC_ADDR_MANID0 10'h114
`define RVC_ADDR_PIN0 10'h116
`define RVC_PRIV_BASE 10'h200

// ****************************************************************
// Variant register fields and reset values
// ****************************************************************
`define RVC_MODE_MSB 2
`define RVC_MODE_LSB 0
`define RVC_INTERVAL_BIT 3
`define RVC_RATE_BIT 4
`define RVC_VARIANT_USED 8'h1f
`define RVC_VARIANT_RST 8'h00
`define RVC_MODE_STD 3'h0
`define RVC_MODE_RSVD 3'h7
`define RVC_FSEL_A_RST 8'h25
`define RVC_FSEL_B_RST 8'h26
`define RVC_FSEL_C_RST 8'h27

// ****************************************************************
// Channel codes and frequencies (MHz)
// ****************************************************************
`define RVC_CODE_LAST_LOW 8'h0a
`define RVC_CODE_LAST_DATA 8'h24
`define RVC_CODE_ADV_A 8'h25
`define RVC_CODE_ADV_B 8'h26
`define RVC_CODE_ADV_C 8'h27
`define RVC_CODE_LAST 8'h4e
`define RVC_BASE_MHZ 12'h960
`define RVC_ADV_A_OFS 12'h002
`define RVC_ADV_B_OFS 12'h01a
`define RVC_ADV_C_OFS 12'h050
`define RVC_LOW_OFS 12'h004
`define RVC_HIGH_OFS 12'h006
`define RVC_CUSTOM_SUB 12'h04d

// ****************************************************************
// Transmission interval timing
// ****************************************************************
`define RVC_INTERVAL_SLOW_MS 20
`define RVC_INTERVAL_FAST_MS 10
`define RVC_CLK_KHZ 100000
`define RVC_CNT_W 21

`endif

/* rvc_pkg.sv */
/*
 * Types of the radio variant and channel configuration bank.
 * Assumes rvc_defs.svh for the address and interval-counter widths.
 */
`include "rvc_defs.svh"

package rvc_pkg;

  typedef logic [`RVC_ADDR_W-1:0] rvc_addr_t;
  typedef logic [11:0] rvc_mhz_t;

  // All state of the configuration bank
  typedef struct packed {
    logic [7:0] variant;
    logic [2:0][7:0] fsel;
    logic [31:0] src;
    logic [15:0] manid;
    logic [31:0] pin;
    logic [127:0] key;
    logic [255:0][7:0] cust;
    logic [7:0] rdata;
    logic rvalid;
    logic [`RVC_CNT_W-1:0] tick_cnt;
    logic tick;
    logic [2:0][11:0] freq;
    logic [2:0] bad;
    logic [1:0] data_cnt;
    logic comm_custom;
    logic data_custom;
    logic fast;
    logic rate2m;
  } rvc_state_s;

endpackage : rvc_pkg

/* rvc_chan_if.sv */
/*
 * Carrier between the bank and its channel-code decoder.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps

interface rvc_chan_if;
  logic [2:0][7:0] code;
  logic [2:0][11:0] freq_mhz;
  logic [2:0] bad;

  modport bank (output code, input freq_mhz, input bad);
  modport dec (input code, output freq_mhz, output bad);
endinterface : rvc_chan_if

/* rvc_chan_decode.sv */
/*
 * Combinational decode of three channel-select codes to frequencies.
 * Assumes the bank registers the results before they leave the block.
 */
`timescale 1ns/100ps

module rvc_chan_decode
(
  rvc_chan_if.dec ch
);
  import rvc_pkg::*;

  // ****************************************************************
  // Code to frequency mapping
  // ****************************************************************

  // Returns {unsupported flag, frequency in MHz}
  function automatic logic [12:0] rvc_map(input logic [7:0] code);
    logic [11:0] c12;
    logic [11:0] ofs;
    logic bad;
    c12 = {4'h0, code};
    bad = 1'b0;
    if (code <= `RVC_CODE_LAST_LOW)
    begin
      ofs = `RVC_LOW_OFS + (c12 << 1);
    end
    else if (code <= `RVC_CODE_LAST_DATA)
    begin
      ofs = `RVC_HIGH_OFS + (c12 << 1);
    end
    else if (code == `RVC_CODE_ADV_A)
    begin
      ofs = `RVC_ADV_A_OFS;
    end
    else if (code == `RVC_CODE_ADV_B)
    begin
      ofs = `RVC_ADV_B_OFS;
    end
    else if (code == `RVC_CODE_ADV_C)
    begin
      ofs = `RVC_ADV_C_OFS;
    end
    else if (code <= `RVC_CODE_LAST)
    begin
      ofs = (c12 << 1) - `RVC_CUSTOM_SUB;
    end
    else
    begin
      ofs = `RVC_ADV_A_OFS;
      bad = 1'b1;
    end
    rvc_map = {bad, `RVC_BASE_MHZ + ofs};
  endfunction : rvc_map

  // One decoder per channel-select register, same encoding for all
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_chan
      assign {ch.bad[i], ch.freq_mhz[i]} = rvc_map(ch.code[i]);
    end
  endgenerate

endmodule : rvc_chan_decode

/* rvc_bank.sv */
/*
 * Radio variant and channel configuration bank of a pushbutton
 * transmitter: variant register, three channel selects, identity
 * settings, customer data area and the sealed private data area.
 * Assumes the commissioning front end presents byte accesses on the
 * same clock, and protected mode and factory reset as clean levels
 * and pulses from that front end.
 */
`timescale 1ns/100ps

// Summary of operation
// - Variant bit 3 clear gives 20 ms interval, set gives 10 ms.
// - Variant bit 4 clear gives 1 Mbit, set gives 2 Mbit.
// - Channel selects steer transmission only for modes 1 to 6.
// - Three one-byte channel selects share one code encoding.
// - Codes 0 to 39 land on even frequencies 2402 to 2480 MHz.
// - Codes 40 to 78 land on odd frequencies 2403 to 2479 MHz.
// - Codes 37, 38, 39 are advertising; 0 to 36 fill the rest.
// - A 256-byte customer area, reachable by the tool only in protected mode.
// - Bank logic never reads or changes the customer area itself.
// - Factory reset leaves the customer area untouched.
// - No external path reads or writes the private data area.
// - A 128-bit key, set at manufacture, is held for authentication.
// - Factory reset restores source address, key, maker code and access code.
// - Variant layout: mode 2:0, interval 3, rate 4, 7:5 reserved.
// - Reserved mode 0b111 behaves as mode zero.
module rvc_bank
#(
  parameter logic [127:0] FACTORY_KEY = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0,
  parameter logic [31:0] FACTORY_SRC = 32'h00000001,  // Arbitrary value
  parameter logic [15:0] FACTORY_MANID = 16'h0001,  // Arbitrary value
  parameter logic [31:0] FACTORY_PIN = 32'h00000000,
  parameter int SLOW_CYC = `RVC_INTERVAL_SLOW_MS * `RVC_CLK_KHZ,
  parameter int FAST_CYC = `RVC_INTERVAL_FAST_MS * `RVC_CLK_KHZ
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic cfg_we_i,
  input wire logic cfg_re_i,
  input wire rvc_pkg::rvc_addr_t cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic prot_mode_i,
  input wire logic factory_reset_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  output logic tx_tick_o,
  output logic rate_2m_o,
  output logic fast_interval_o,
  output logic comm_custom_o,
  output logic data_custom_o,
  output logic [1:0] data_chan_cnt_o,
  output rvc_pkg::rvc_mhz_t freq_a_o,
  output rvc_pkg::rvc_mhz_t freq_b_o,
  output rvc_pkg::rvc_mhz_t freq_c_o,
  output logic [2:0] code_bad_o,
  output logic [127:0] key_o,
  output logic [47:0] src_addr_o,
  output logic [15:0] manid_o
);
  import rvc_pkg::*;

  // ****************************************************************
  // Constants
  // ****************************************************************

  // Upper 16 source-address bits; arbitrary value
  localparam logic [15:0] SRC_PREFIX = 16'h5a5a;
  // Terminal counts of the interval timer; the counter runs from zero
  // up to the limit, so one period spans exactly the chosen cycle count
  localparam logic [`RVC_CNT_W-1:0] SLOW_LIM = `RVC_CNT_W'(SLOW_CYC - 1);
  localparam logic [`RVC_CNT_W-1:0] FAST_LIM = `RVC_CNT_W'(FAST_CYC - 1);

  // ****************************************************************
  // State and internal signals
  // ****************************************************************

  // Registered bank state and its next value
  rvc_state_s q;
  rvc_state_s d;
  // Carrier to and from the channel decoder
  rvc_chan_if ch ();
  // Variant fields taken from the stored register
  logic [2:0] mode;
  logic custom_on;
  // Regions of the configuration address space
  logic in_cust;
  logic in_priv;
  // Terminal count in force for the present interval
  logic [`RVC_CNT_W-1:0] lim;

  // ****************************************************************
  // Channel decoder
  // ****************************************************************

  // Decoder sees the stored channel codes
  // so the frequencies change only after a select write has landed
  assign ch.code = q.fsel;

  rvc_chan_decode u_dec
  (
    .ch (ch)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************

  // Region decode of the configuration port; the private area has no
  // decode into any field, so no access can reach the key or backups
  assign in_cust = (cfg_addr_i <= `RVC_CUST_LAST);
  assign in_priv = (cfg_addr_i >= `RVC_PRIV_BASE);

  // ****************************************************************
  // Variant field decode
  // ****************************************************************

  // Reserved mode folds onto standard advertising
  assign mode = q.variant[`RVC_MODE_MSB:`RVC_MODE_LSB];
  assign custom_on = (mode != `RVC_MODE_STD) && (mode != `RVC_MODE_RSVD);
  assign lim = q.variant[`RVC_INTERVAL_BIT] ? FAST_LIM : SLOW_LIM;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Register writes, reads, factory restore, interval timer and outputs
  always_comb
  begin
    d = q;
    d.rvalid = 1'b0;
    d.tick = 1'b0;
    // Configuration writes
    // Private and unmapped writes fall through untouched
    if (cfg_we_i && !in_priv)
    begin
      if (in_cust)
      begin
        if (prot_mode_i)
        begin
          d.cust[cfg_addr_i[7:0]] = cfg_wdata_i;
        end
      end
      else
      begin
        case (cfg_addr_i)
          `RVC_ADDR_VARIANT: d.variant = cfg_wdata_i & `RVC_VARIANT_USED;
          `RVC_ADDR_FSEL_A: d.fsel[0] = cfg_wdata_i;
          `RVC_ADDR_FSEL_B: d.fsel[1] = cfg_wdata_i;
          `RVC_ADDR_FSEL_C: d.fsel[2] = cfg_wdata_i;
          `RVC_ADDR_SRC0: d.src[7:0] = cfg_wdata_i;
          `RVC_ADDR_SRC0 + 10'h001: d.src[15:8] = cfg_wdata_i;
          `RVC_ADDR_SRC0 + 10'h002: d.src[23:16] = cfg_wdata_i;
          `RVC_ADDR_SRC0 + 10'h003: d.src[31:24] = cfg_wdata_i;
          `RVC_ADDR_MANID0: d.manid[7:0] = cfg_wdata_i;
          `RVC_ADDR_MANID0 + 10'h001: d.manid[15:8] = cfg_wdata_i;
          `RVC_ADDR_PIN0: d.pin[7:0] = cfg_wdata_i;
          `RVC_ADDR_PIN0 + 10'h001: d.pin[15:8] = cfg_wdata_i;
          `RVC_ADDR_PIN0 + 10'h002: d.pin[23:16] = cfg_wdata_i;
          `RVC_ADDR_PIN0 + 10'h003: d.pin[31:24] = cfg_wdata_i;
          default: d.variant = d.variant;
        endcase
      end
    end

    // Configuration reads, one cycle later; private and unmapped read zero
    if (cfg_re_i)
    begin
      d.rvalid = 1'b1;
      d.rdata = 8'h00;
      if (in_priv)
      begin
        d.rdata = 8'h00;
      end
      else if (in_cust)
      begin
        d.rdata = prot_mode_i ? q.cust[cfg_addr_i[7:0]] : 8'h00;
      end
      else
      begin
        case (cfg_addr_i)
          `RVC_ADDR_VARIANT: d.rdata = q.variant;
          `RVC_ADDR_FSEL_A: d.rdata = q.fsel[0];
          `RVC_ADDR_FSEL_B: d.rdata = q.fsel[1];
          `RVC_ADDR_FSEL_C: d.rdata = q.fsel[2];
          `RVC_ADDR_SRC0: d.rdata = q.src[7:0];
          `RVC_ADDR_SRC0 + 10'h001: d.rdata = q.src[15:8];
          `RVC_ADDR_SRC0 + 10'h002: d.rdata = q.src[23:16];
          `RVC_ADDR_SRC0 + 10'h003: d.rdata = q.src[31:24];
          `RVC_ADDR_MANID0: d.rdata = q.manid[7:0];
          `RVC_ADDR_MANID0 + 10'h001: d.rdata = q.manid[15:8];
          `RVC_ADDR_PIN0: d.rdata = q.pin[7:0];
          `RVC_ADDR_PIN0 + 10'h001: d.rdata = q.pin[15:8];
          `RVC_ADDR_PIN0 + 10'h002: d.rdata = q.pin[23:16];
          `RVC_ADDR_PIN0 + 10'h003: d.rdata = q.pin[31:24];
          default: d.rdata = 8'h00;
        endcase
      end
    end

    // Factory restore wins over a same-cycle write; customer area untouched
    // The backups live only here, as parameters outside the address map
    if (factory_reset_i)
    begin
      d.src = FACTORY_SRC;
      d.key = FACTORY_KEY;
      d.manid = FACTORY_MANID;
      d.pin = FACTORY_PIN;
    end

    // Interval timer restarts when the limit shrinks below the count
    // Switching to the short interval may thus tick at once
    if (q.tick_cnt >= lim)
    begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.tick_cnt = q.tick_cnt + `RVC_CNT_W'(1);
    end

    // Radio settings from the variant register and channel decoder
    // Registered once more so every output leaves from a flip-flop
    d.fast = q.variant[`RVC_INTERVAL_BIT];
    d.rate2m = q.variant[`RVC_RATE_BIT];
    d.comm_custom = custom_on && mode[2];
    d.data_custom = custom_on;
    case (mode)
      3'h1, 3'h4: d.data_cnt = 2'h3;
      3'h2, 3'h5: d.data_cnt = 2'h2;
      3'h3, 3'h6: d.data_cnt = 2'h1;
      default: d.data_cnt = 2'h3;
    endcase
    for (int i = 0; i < 3; i++)
    begin
      d.freq[i] = ch.freq_mhz[i];
      d.bad[i] = ch.bad[i];
    end

    // Synchronous reset restores settings; stored customer bytes persist
    // Reset comes last so that it overrides every access in its cycle
    if (srst_i)
    begin
      d = '0;
      d.cust = q.cust;
      d.variant = `RVC_VARIANT_RST;
      d.fsel[0] = `RVC_FSEL_A_RST;
      d.fsel[1] = `RVC_FSEL_B_RST;
      d.fsel[2] = `RVC_FSEL_C_RST;
      d.src = FACTORY_SRC;
      d.key = FACTORY_KEY;
      d.manid = FACTORY_MANID;
      d.pin = FACTORY_PIN;
      d.data_cnt = 2'h3;
      d.freq[0] = `RVC_BASE_MHZ + `RVC_ADV_A_OFS;
      d.freq[1] = `RVC_BASE_MHZ + `RVC_ADV_B_OFS;
      d.freq[2] = `RVC_BASE_MHZ + `RVC_ADV_C_OFS;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Whole bank state in one register
  always_ff @(posedge ref_clk_i)
  begin
    q <= d;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All outputs come straight from the state register, bar the SRC_PREFIX top of src_addr_o
  // Read answer of the configuration port
  assign cfg_rdata_o = q.rdata;
  assign cfg_rvalid_o = q.rvalid;

  // Interval tick and radio settings
  assign tx_tick_o = q.tick;
  assign rate_2m_o = q.rate2m;
  assign fast_interval_o = q.fast;
  assign comm_custom_o = q.comm_custom;
  assign data_custom_o = q.data_custom;
  assign data_chan_cnt_o = q.data_cnt;

  // Channel frequencies and fallback flags
  assign freq_a_o = q.freq[0];
  assign freq_b_o = q.freq[1];
  assign freq_c_o = q.freq[2];
  assign code_bad_o = q.bad;

  // Identity settings; the key goes to the radio only, never to the port
  assign key_o = q.key;
  assign src_addr_o = {SRC_PREFIX, q.src};
  assign manid_o = q.manid;

endmodule : rvc_bank

/* rvc_bank_sva.sv */
/*
 * Checker of the configuration bank port behaviour.
 * Assumes binding to rvc_bank with its parameters handed on.
 */
`timescale 1ns/100ps
`include "rvc_defs.svh"

// ****************************************************************
// Checker
// ****************************************************************
module rvc_bank_sva
#(
  parameter int SLOW_CYC = 20,
  parameter logic [127:0] FACTORY_KEY = '0
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic cfg_we_i,
  input wire logic cfg_re_i,
  input wire rvc_pkg::rvc_addr_t cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic prot_mode_i,
  input wire logic factory_reset_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic tx_tick_o,
  input wire logic rate_2m_o,
  input wire logic fast_interval_o,
  input wire rvc_pkg::rvc_mhz_t freq_a_o,
  input wire logic [2:0] code_bad_o,
  input wire logic [127:0] key_o
);
  import rvc_pkg::*;
  logic [31:0] gap_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Cycles since the last interval tick
  always_ff @(posedge ref_clk_i)
  begin
    gap_q <= (srst_i || tx_tick_o) ? 32'h0 : gap_q + 32'h1;
  end

  a_read_answer: assert property (cfg_re_i |=> cfg_rvalid_o)
    else $error("read not answered next cycle");
  a_answer_cause: assert property (cfg_rvalid_o |-> $past(cfg_re_i))
    else $error("read answer without request");
  a_private_sealed: assert property (cfg_re_i && cfg_addr_i >= 10'h200 |=> cfg_rdata_o == 8'h00)
    else $error("private area readable");
  a_cust_locked: assert property (cfg_re_i && cfg_addr_i <= 10'h0ff && !prot_mode_i
    |=> cfg_rdata_o == 8'h00)
    else $error("customer area readable unprotected");
  a_rate_follow: assert property (cfg_we_i && cfg_addr_i == `RVC_ADDR_VARIANT
    |-> ##2 rate_2m_o == $past(cfg_wdata_i[4], 2))
    else $error("rate does not follow bit 4");
  a_interval_follow: assert property (cfg_we_i && cfg_addr_i == `RVC_ADDR_VARIANT
    |-> ##2 fast_interval_o == $past(cfg_wdata_i[3], 2))
    else $error("interval does not follow bit 3");
  a_key_restore: assert property (factory_reset_i |=> key_o == FACTORY_KEY)
    else $error("key not restored");
  a_tick_pulse: assert property (tx_tick_o |=> !tx_tick_o [*8])
    else $error("ticks too close");
  a_tick_bound: assert property (gap_q <= SLOW_CYC)
    else $error("tick interval too long");
  a_bad_fallback: assert property (code_bad_o[0] |-> freq_a_o == 12'h962)
    else $error("bad code not on fallback");
  a_freq_range: assert property (freq_a_o >= 12'h962 && freq_a_o <= 12'h9b0)
    else $error("frequency outside band");

  c_read: cover property (cfg_rvalid_o);
  c_restore: cover property (factory_reset_i);
  c_bad: cover property (code_bad_o[0]);
endmodule : rvc_bank_sva

/* rvc_tool.sv */
/*
 * Commissioning tool model driving the byte configuration port.
 * Assumes the same clock as the bank; drives just after each edge.
 */
`timescale 1ns/100ps

// ****************************************************************
// Tool model
// ****************************************************************
module rvc_tool
(
  input wire logic ref_clk_i,
  input wire logic [7:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i,
  output logic cfg_we_o,
  output logic cfg_re_o,
  output rvc_pkg::rvc_addr_t cfg_addr_o,
  output logic [7:0] cfg_wdata_o,
  output logic prot_mode_o,
  output logic factory_reset_o
);
  import rvc_pkg::*;

  // Idle port at time zero
  initial
  begin
    {cfg_we_o, cfg_re_o, prot_mode_o, factory_reset_o} = 4'h0;
    cfg_addr_o = 10'h155;
    cfg_wdata_o = 8'h5a;
  end

  // Byte write; released lines show the inverse of the last value
  task automatic wr(input rvc_addr_t a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    cfg_addr_o = a;
    cfg_wdata_o = d;
    cfg_we_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    cfg_we_o = 1'b0;
    cfg_addr_o = ~a;
    cfg_wdata_o = ~d;
  endtask : wr

  // Byte read, answer taken one cycle after the request
  task automatic rd(input rvc_addr_t a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_i);
    #1;
    cfg_addr_o = a;
    cfg_re_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    cfg_re_o = 1'b0;
    cfg_addr_o = ~a;
    d = cfg_rdata_i;
    v = cfg_rvalid_i;
  endtask : rd

  // Customer area is reached only with protected mode entered
  task automatic set_prot(input logic p);
    @(posedge ref_clk_i);
    #1;
    prot_mode_o = p;
  endtask : set_prot

  // One-cycle factory reset request
  task automatic restore;
    @(posedge ref_clk_i);
    #1;
    factory_reset_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    factory_reset_o = 1'b0;
  endtask : restore
endmodule : rvc_tool

/* tb_top.sv */
/*
 * Self-checking bench of the configuration bank.
 * Assumes rvc_tool drives the port; short interval counts used.
 */
`timescale 1ns/100ps
`include "rvc_defs.svh"

// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
  import rvc_pkg::*;
  localparam logic [127:0] KEY = 128'h0123_4567_89ab_cdef_0011_2233_4455_6677;
  localparam logic [31:0] SRC = 32'h0000_1234;  // Arbitrary value
  localparam logic [15:0] MANID = 16'h00a7;  // Arbitrary value
  localparam logic [31:0] PIN = 32'h0000_2468;  // Arbitrary value
  logic ref_clk_i, srst_i, we, re, prot, frst, rvalid, tick, rate, fast, comm, datac;
  rvc_addr_t addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] cnt;
  logic [2:0] bad;
  rvc_mhz_t fa, fb, fc;
  logic [127:0] key;
  logic [47:0] src;
  logic [15:0] manid;
  logic v;
  int err_total, tests_run, cyc;

  // Clock, 10 ns period
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  rvc_bank #(.FACTORY_KEY(KEY), .FACTORY_SRC(SRC), .FACTORY_MANID(MANID), .FACTORY_PIN(PIN),
    .SLOW_CYC(20), .FAST_CYC(10)) dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_we_i(we), .cfg_re_i(re),
    .cfg_addr_i(addr), .cfg_wdata_i(wdata), .prot_mode_i(prot), .factory_reset_i(frst),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .tx_tick_o(tick), .rate_2m_o(rate),
    .fast_interval_o(fast), .comm_custom_o(comm), .data_custom_o(datac),
    .data_chan_cnt_o(cnt), .freq_a_o(fa), .freq_b_o(fb), .freq_c_o(fc),
    .code_bad_o(bad), .key_o(key), .src_addr_o(src), .manid_o(manid));

  rvc_tool tool (.ref_clk_i(ref_clk_i), .cfg_rdata_i(rdata), .cfg_rvalid_i(rvalid),
    .cfg_we_o(we), .cfg_re_o(re), .cfg_addr_o(addr), .cfg_wdata_o(wdata),
    .prot_mode_o(prot), .factory_reset_o(frst));

  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step

  // Expected frequency from the channel code
  function automatic logic [11:0] exp_f(input logic [7:0] c);
    logic [11:0] x;
    x = {3'h0, c, 1'b0};
    if (c > 8'h4e || c == 8'h25) return 12'h962;
    if (c >= 8'h28) return 12'h913 + x;
    if (c == 8'h26) return 12'h97a;
    if (c == 8'h27) return 12'h9b0;
    return (c <= 8'h0a) ? 12'h964 + x : 12'h966 + x;
  endfunction : exp_f

  task automatic t_reset;
    chk("freq_abc", 36'h962_97a_9b0, {fa, fb, fc});
    chk("rate_fast", 2'b00, {rate, fast});
    chk("key", KEY, key);
    tool.rd(`RVC_ADDR_FSEL_B, d, v);
    chk("fsel_b", 9'h126, {v, d});
  endtask : t_reset

  task automatic t_variant;
    logic [3:0] e;
    for (int m = 0; m < 8; m++)
    begin
      tool.wr(`RVC_ADDR_VARIANT, {3'h5, 2'h3, m[2:0]});
      step(2);
      e[3] = (m >= 4 && m <= 6);
      e[2] = (m >= 1 && m <= 6);
      e[1:0] = (m == 2 || m == 5) ? 2'h2 : (m == 3 || m == 6) ? 2'h1 : 2'h3;
      chk("mode", {e, 2'h3}, {comm, datac, cnt, rate, fast});
    end
    tool.rd(`RVC_ADDR_VARIANT, d, v);
    chk("variant", 8'h1f, d);
    tool.wr(`RVC_ADDR_VARIANT, 8'h00);
    step(2);
    chk("defaults", 2'b00, {rate, fast});
  endtask : t_variant

  task automatic t_chan;
    logic [7:0] codes [12] = '{8'h00, 8'h0a, 8'h0b, 8'h24, 8'h25, 8'h26,
                               8'h27, 8'h28, 8'h29, 8'h4f, 8'h4e, 8'hff};
    logic [1:0] s;
    for (int k = 0; k < 12; k++)
    begin
      s = 2'(k % 3);
      tool.wr(rvc_addr_t'(`RVC_ADDR_FSEL_A + s), codes[k]);
      step(2);
      chk("freq", exp_f(codes[k]), s == 0 ? fa : s == 1 ? fb : fc);
      chk("code_bad", codes[k] > 8'h4e, bad[s]);
    end
  endtask : t_chan

  task automatic t_cust;
    tool.set_prot(1'b1);
    tool.wr(10'h0ff, 8'ha5);
    tool.rd(10'h0ff, d, v);
    chk("cust_prot", 8'ha5, d);
    tool.set_prot(1'b0);
    tool.wr(10'h0ff, 8'h3c);
    tool.rd(10'h0ff, d, v);
    chk("cust_unprot", 8'h00, d);
    tool.wr(`RVC_ADDR_SRC0, 8'h77);
    tool.wr(`RVC_ADDR_MANID0 + 10'h001, 8'h3e);
    tool.wr(`RVC_ADDR_PIN0, 8'h42);
    step(2);
    chk("src_new", 8'h77, src[7:0]);
    chk("manid_new", 8'h3e, manid[15:8]);
    tool.rd(`RVC_ADDR_PIN0, d, v);
    chk("pin_new", 8'h42, d);
    tool.restore();
    step(2);
    chk("src_restore", {16'h5a5a, SRC}, src);
    chk("key_restore", KEY, key);
    chk("manid_restore", MANID, manid);
    tool.rd(`RVC_ADDR_PIN0, d, v);
    chk("pin_restore", PIN[7:0], d);
    tool.set_prot(1'b1);
    tool.rd(10'h0ff, d, v);
    chk("cust_kept", 8'ha5, d);
  endtask : t_cust

  task automatic t_priv;
    tool.wr(`RVC_PRIV_BASE, 8'h55);
    tool.rd(`RVC_PRIV_BASE, d, v);
    chk("priv_rd", 9'h100, {v, d});
    tool.rd(10'h3ff, d, v);
    chk("priv_top", 8'h00, d);
    chk("key_sealed", KEY, key);
  endtask : t_priv

  task automatic t_tick(input logic [7:0] var_v, input logic [7:0] per);
    logic [7:0] n;
    tool.wr(`RVC_ADDR_VARIANT, var_v);
    n = 0;
    while (tick !== 1'b1 && n < 8'h40)
    begin
      step(1);
      n++;
    end
    n = 0;
    do
    begin
      step(1);
      n++;
    end
    while (tick !== 1'b1 && n < 8'h40);
    chk("tick_period", per, n);
  endtask : t_tick

  // Main sequence
  initial
  begin
    srst_i = 1'b1;
    step(2);
    srst_i = 1'b0;
    t_reset();
    t_variant();
    t_chan();
    t_cust();
    t_priv();
    t_tick(8'h00, 8'h14);
    t_tick(8'h08, 8'h0a);
    stop_test();
  end

  // Cut a hang short
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
endmodule : tb_top

bind rvc_bank rvc_bank_sva #(.SLOW_CYC(SLOW_CYC), .FACTORY_KEY(FACTORY_KEY)) u_sva (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .cfg_we_i(cfg_we_i), .cfg_re_i(cfg_re_i),
  .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .prot_mode_i(prot_mode_i),
  .factory_reset_i(factory_reset_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_rvalid_o(cfg_rvalid_o), .tx_tick_o(tx_tick_o), .rate_2m_o(rate_2m_o),
  .fast_interval_o(fast_interval_o), .freq_a_o(freq_a_o), .code_bad_o(code_bad_o),
  .key_o(key_o));
